// [logic/pcoc_defs.svh]
`ifndef PCOC_DEFS_SVH
`define PCOC_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PCOC_ADDR_CTRL 8'h00
`define PCOC_ADDR_PRESET 8'h04
`define PCOC_ADDR_DELAY 8'h08
`define PCOC_ADDR_COUNT 8'h0c
`define PCOC_ADDR_DISPLAY 8'h10
`define PCOC_ADDR_STATUS 8'h14

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define PCOC_F_EDGE_LSB 0
`define PCOC_F_SCALE_LSB 2
`define PCOC_F_DP_LSB 5
`define PCOC_F_DP_NEG 8
`define PCOC_F_RMODE_LSB 9
`define PCOC_F_RMOM 12
`define PCOC_F_TMODE_LSB 13
`define PCOC_F_REV 16
`define PCOC_F_PANEL_EN 17
`define PCOC_F_QUAD4 18
`define PCOC_F_DOWN 19

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define PCOC_EDGE_SINGLE 2'h1
`define PCOC_EDGE_TWO 2'h2
`define PCOC_RST_EDGE 2'h1
`define PCOC_RST_SCALE 3'h1
`define PCOC_RST_DP 3'h1
`define PCOC_RST_RMODE 3'h1
`define PCOC_RST_TMODE 3'h3
`define PCOC_RST_DELAY 16'h0064
`define PCOC_DELAY_MAX 16'hea5f

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PCOC_TICK_MS 10
`define PCOC_CLK_KHZ 100000
`define PCOC_TICK_CYCLES (`PCOC_TICK_MS * `PCOC_CLK_KHZ)

`endif

// [logic/pcoc_pkg.sv]
package pcoc_pkg;

  typedef logic signed [31:0] pcoc_count_t;
  typedef logic [31:0] pcoc_word_t;

  typedef struct packed {
    logic cnt_s1;
    logic cnt_s2;
    logic cnt_prev;
    logic rst_s1;
    logic rst_s2;
    logic btn_s1;
    logic btn_s2;
    logic man_prev;
    logic out2_prev;
    logic [1:0] edge_code;
    logic [2:0] scale_code;
    logic [2:0] dp_pos;
    logic dp_neg;
    logic [2:0] rmode;
    logic rmom;
    logic [2:0] tmode;
    logic reverse;
    logic panel_en;
    logic quad4;
    logic count_down;
    pcoc_count_t preset;
    logic [15:0] delay;
    pcoc_count_t count;
    logic [15:0] timer;
    logic timer_run;
    logic [19:0] tick_cnt;
    logic active;
    logic init;
    pcoc_count_t display;
    logic [5:0] dp_mask;
    logic lzb;
    logic out1_pin;
    logic boundary;
    pcoc_word_t rdata;
  } pcoc_state_s;

endpackage

// [logic/pcoc_core.sv]
`include "pcoc_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module pcoc_core #(
  parameter int TICK_CYCLES = `PCOC_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // field inputs
  input wire logic count_in,
  input wire logic remote_reset_n,
  input wire logic panel_button,
  // second output state and saved boundary
  input wire logic out2_active,
  input wire logic boundary_saved,
  // outputs
  output logic out1_pin,
  output logic boundary_state,
  output pcoc_pkg::pcoc_count_t display,
  output logic [5:0] dp_mask,
  output logic leading_zero_blank
);
  import pcoc_pkg::*;

  pcoc_state_s q;
  pcoc_state_s n;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // divide by the selected scale multiplier
  function automatic pcoc_count_t scale_div(input pcoc_count_t c, input logic [2:0] code);
    pcoc_count_t r;
    r = c;
    unique case (code)
      3'h2: r = c / 32'sd10;
      3'h3: r = c / 32'sd100;
      3'h4: r = c / 32'sd1000;
      default: r = c;
    endcase
    return r;
  endfunction

  // one-hot decimal point, digit 1 never lit
  function automatic logic [5:0] dp_decode(input logic [2:0] pos);
    logic [5:0] m;
    m = 6'h00;
    unique case (pos)
      3'h2: m = 6'h02;
      3'h3: m = 6'h04;
      3'h4: m = 6'h08;
      3'h5: m = 6'h10;
      3'h6: m = 6'h20;
      default: m = 6'h00;
    endcase
    return m;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------

  logic man;
  logic man_rise;
  logic man_fall;
  logic tick;
  logic fall_e;
  logic rise_e;
  logic step;
  logic to_preset;
  logic mom_eff;
  logic hit;
  logic act_evt;
  logic expire;
  logic bnd;
  logic o2_rise;
  logic o2_fall;
  pcoc_count_t next_cnt;
  pcoc_count_t target;

  // all state updates
  always_comb begin
    n = q;

    // two-stage synchronisers on pins
    n.cnt_s1 = count_in;
    n.cnt_s2 = q.cnt_s1;
    n.cnt_prev = q.cnt_s2;
    n.rst_s1 = remote_reset_n;
    n.rst_s2 = q.rst_s1;
    n.btn_s1 = panel_button;
    n.btn_s2 = q.btn_s1;

    // manual reset request and its edges
    man = ~q.rst_s2 | (q.btn_s2 & q.panel_en);
    man_rise = man & ~q.man_prev;
    man_fall = ~man & q.man_prev;
    n.man_prev = man;
    o2_rise = out2_active & ~q.out2_prev;
    o2_fall = ~out2_active & q.out2_prev;
    n.out2_prev = out2_active;

    // 10 ms time base
    tick = (q.tick_cnt == 20'(TICK_CYCLES - 1));
    n.tick_cnt = tick ? 20'h00000 : q.tick_cnt + 20'h00001;

    // count edge selection
    fall_e = q.cnt_prev & ~q.cnt_s2;
    rise_e = ~q.cnt_prev & q.cnt_s2;
    step = fall_e | (rise_e & (q.edge_code == `PCOC_EDGE_TWO));
    next_cnt = q.count_down ? q.count - 32'sd1 : q.count + 32'sd1;

    // reset target and mode decode
    to_preset = (q.rmode == 3'h2) | (q.rmode == 3'h4) | (q.rmode == 3'h6);
    target = to_preset ? q.preset : 32'sh00000000;
    mom_eff = q.rmom & ((q.rmode == 3'h1) | (q.rmode == 3'h2));

    // output start event
    hit = (q.rmode == 3'h6) ? (next_cnt == 32'sh00000000) : (next_cnt == q.preset);
    act_evt = step & hit;

    // output delay timer
    expire = q.timer_run & tick & (q.timer == 16'h0001);
    if (q.timer_run && tick) begin
      n.timer = q.timer - 16'h0001;
      if (expire) begin
        n.timer_run = 1'b0;
      end
    end
    if (act_evt) begin
      n.timer = q.delay;
      n.timer_run = 1'b1;
    end
    if (man && !mom_eff) begin
      n.timer_run = 1'b0;
    end else if (man_rise) begin
      n.timer_run = 1'b0;
    end

    // count register
    n.count = step ? next_cnt : q.count;
    if (act_evt && q.rmode == 3'h5) begin
      n.count = 32'sh00000000;
    end
    if (act_evt && q.rmode == 3'h6) begin
      n.count = q.preset;
    end
    if (expire && (q.rmode == 3'h3 || q.rmode == 3'h4)) begin
      n.count = target;
    end
    if (mom_eff) begin
      if (man_rise) begin
        n.count = target;
      end
    end else if (man) begin
      n.count = target;
    end

    // output 1 state
    bnd = q.preset[31] ? (q.count <= q.preset) : (q.count >= q.preset);
    n.boundary = bnd;
    unique case (q.tmode)
      3'h1: if (o2_rise) n.active = 1'b0;
      3'h2: if (o2_fall) n.active = 1'b0;
      3'h3: if (man_rise) n.active = 1'b0;
      3'h4: if (man_fall) n.active = 1'b0;
      3'h5: if (expire || man) n.active = 1'b0;
      default: n.active = q.active;
    endcase
    if (act_evt && q.tmode != 3'h6) begin
      n.active = 1'b1;
    end
    if (q.tmode == 3'h6) begin
      n.active = q.init ? boundary_saved : bnd;
    end
    n.init = 1'b0;
    n.out1_pin = n.active ^ q.reverse;

    // display, frozen during a momentary reset
    if (!(mom_eff && man)) begin
      n.display = scale_div(q.count, q.scale_code);
    end
    n.dp_mask = dp_decode(q.dp_pos);
    n.lzb = ~q.dp_neg;

    // register writes
    if (wr) begin
      unique case (addr)
        `PCOC_ADDR_CTRL: begin
          if (!q.quad4) begin
            n.edge_code = wdata[`PCOC_F_EDGE_LSB +: 2];
          end
          n.scale_code = wdata[`PCOC_F_SCALE_LSB +: 3];
          n.dp_pos = wdata[`PCOC_F_DP_LSB +: 3];
          n.dp_neg = wdata[`PCOC_F_DP_NEG];
          n.rmode = wdata[`PCOC_F_RMODE_LSB +: 3];
          n.rmom = wdata[`PCOC_F_RMOM];
          n.tmode = wdata[`PCOC_F_TMODE_LSB +: 3];
          n.reverse = wdata[`PCOC_F_REV];
          n.panel_en = wdata[`PCOC_F_PANEL_EN];
          n.quad4 = wdata[`PCOC_F_QUAD4];
          n.count_down = wdata[`PCOC_F_DOWN];
        end
        `PCOC_ADDR_PRESET: n.preset = wdata;
        `PCOC_ADDR_DELAY: begin
          if (wdata[15:0] != 16'h0000 && wdata[15:0] <= `PCOC_DELAY_MAX) begin
            n.delay = wdata[15:0];
          end
        end
        default: n.preset = q.preset;
      endcase
    end

    // register reads, data valid for one cycle
    n.rdata = 32'h00000000;
    if (rd) begin
      unique case (addr)
        `PCOC_ADDR_CTRL: begin
          n.rdata[`PCOC_F_EDGE_LSB +: 2] = q.edge_code;
          n.rdata[`PCOC_F_SCALE_LSB +: 3] = q.scale_code;
          n.rdata[`PCOC_F_DP_LSB +: 3] = q.dp_pos;
          n.rdata[`PCOC_F_DP_NEG] = q.dp_neg;
          n.rdata[`PCOC_F_RMODE_LSB +: 3] = q.rmode;
          n.rdata[`PCOC_F_RMOM] = q.rmom;
          n.rdata[`PCOC_F_TMODE_LSB +: 3] = q.tmode;
          n.rdata[`PCOC_F_REV] = q.reverse;
          n.rdata[`PCOC_F_PANEL_EN] = q.panel_en;
          n.rdata[`PCOC_F_QUAD4] = q.quad4;
          n.rdata[`PCOC_F_DOWN] = q.count_down;
        end
        `PCOC_ADDR_PRESET: n.rdata = q.preset;
        `PCOC_ADDR_DELAY: n.rdata = {16'h0000, q.delay};
        `PCOC_ADDR_COUNT: n.rdata = q.count;
        `PCOC_ADDR_DISPLAY: n.rdata = q.display;
        `PCOC_ADDR_STATUS: n.rdata = {24'h000000, q.boundary, man, q.timer_run,
                                      q.lzb, 2'h0, q.out1_pin, q.active};
        default: n.rdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------

  // power-up values, output forced inactive
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.rst_s1 <= 1'b1;
      q.rst_s2 <= 1'b1;
      q.edge_code <= `PCOC_RST_EDGE;
      q.scale_code <= `PCOC_RST_SCALE;
      q.dp_pos <= `PCOC_RST_DP;
      q.rmode <= `PCOC_RST_RMODE;
      q.tmode <= `PCOC_RST_TMODE;
      q.panel_en <= 1'b1;
      q.delay <= `PCOC_RST_DELAY;
      q.lzb <= 1'b1;
      q.init <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata = q.rdata;
  assign out1_pin = q.out1_pin;
  assign boundary_state = q.boundary;
  assign display = q.display;
  assign dp_mask = q.dp_mask;
  assign leading_zero_blank = q.lzb;

endmodule

`default_nettype wire

// [dv/pcoc_core_asserts.sv]
`timescale 1ns/100ps
`default_nettype none

module pcoc_core_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  // field pins
  input wire logic remote_reset_n,
  input wire logic panel_button,
  // outputs
  input wire logic out1_pin,
  input wire logic boundary_state,
  input wire pcoc_pkg::pcoc_count_t display,
  input wire logic [5:0] dp_mask,
  input wire logic leading_zero_blank
);
  import pcoc_pkg::*;
  logic [31:0] ctrl_q;
  logic [5:0] dp_exp;
  // shadow of the control word
  always_ff @(posedge clk) begin
    if (reset) ctrl_q <= 32'h00026225;
    else if (wr && addr == 8'h00) ctrl_q <= wdata;
  end
  // expected point position, setting 1 lights nothing
  always_comb begin
    dp_exp = 6'h00;
    if (ctrl_q[7:5] inside {[3'h2:3'h6]}) dp_exp = 6'(6'h01 << (ctrl_q[7:5] - 3'h1));
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_dp_rightmost: assert property (dp_mask[0] == 1'b0)
    else $error("rightmost point lit");
  a_dp_place: assert property ((!wr)[*3] |-> dp_mask == dp_exp)
    else $error("point in wrong digit");
  a_lzb_sign: assert property ((!wr)[*3] |-> leading_zero_blank == !ctrl_q[8])
    else $error("blanking does not follow sign");
  a_hold_zero: assert property ((!wr && !remote_reset_n && ctrl_q[12:9] == 4'h1)[*8]
    |-> display == '0) else $error("count not held at zero");
  a_frozen_disp: assert property ((!wr && !remote_reset_n && ctrl_q[12:9] == 4'h9)[*8]
    |-> $stable(display)) else $error("display moved during reset");
  a_pin_idle: assert property ($fell(reset) |-> !out1_pin)
    else $error("output active after reset");
  a_latch_held: assert property ((ctrl_q[16:13] == 4'h3 && out1_pin && remote_reset_n
    && !panel_button && !wr)[*3] |=> out1_pin) else $error("latched output dropped");
  a_hold_through: assert property ((ctrl_q[16:13] == 4'h4 && out1_pin && !remote_reset_n
    && !wr)[*3] |=> out1_pin) else $error("output dropped during reset");
  a_bound_track: assert property ((ctrl_q[15:13] == 3'h6 && !wr && $stable(boundary_state))[*3]
    |-> out1_pin == (boundary_state ^ ctrl_q[16])) else $error("boundary output wrong");
endmodule

bind pcoc_core pcoc_core_chk chk_u (.clk, .reset, .addr, .wdata, .wr, .remote_reset_n,
  .panel_button, .out1_pin, .boundary_state, .display, .dp_mask, .leading_zero_blank);

`default_nettype wire

// [dv/pcoc_field.sv]
`timescale 1ns/100ps
`default_nettype none

module pcoc_field (
  // clock
  input wire logic clk,
  // field pins
  output logic count_in,
  output logic remote_reset_n,
  output logic panel_button
);
  // pins rest inactive
  initial begin
    count_in = 1'b1;
    remote_reset_n = 1'b1;
    panel_button = 1'b0;
  end
  // sensor pulses, each level held at least two clocks, then settle time
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      count_in <= 1'b0;
      repeat (2) @(posedge clk);
      count_in <= 1'b1;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
  // manual reset from terminal or panel button, held long enough to sync
  task automatic hold(input logic on, input logic btn);
    @(posedge clk);
    if (btn) panel_button <= on;
    else remote_reset_n <= !on;
    repeat (6) @(posedge clk);
  endtask
endmodule

`default_nettype wire

// [dv/pcoc_core_bench.sv]
`timescale 1ns/100ps
`default_nettype none

module pcoc_core_bench;
  import pcoc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic out2_active = 1'b0;
  logic boundary_saved = 1'b0;
  logic [31:0] rdata, v;
  logic count_in, remote_reset_n, panel_button, out1_pin, boundary_state, leading_zero_blank;
  pcoc_count_t display;
  logic [5:0] dp_mask;
  int err_count = 0;
  int n_checks = 0;
  int k;
  // clock
  always #5 clk = ~clk;
  pcoc_core #(.TICK_CYCLES(10)) dut_u (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata,
    .count_in, .remote_reset_n, .panel_button, .out2_active, .boundary_saved, .out1_pin,
    .boundary_state, .display, .dp_mask, .leading_zero_blank);
  pcoc_field field_u (.clk, .count_in, .remote_reset_n, .panel_button);
  // control word with panel reset enabled
  function automatic logic [31:0] cw(input int e, input int s, input int p, input int r,
      input int t);
    return 32'(32'h20000 | e | s << 2 | p << 5 | r << 9 | t << 13);
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    chk(nm, v, exp);
  endtask
  task automatic t_regs();
    chk("out1 after reset", out1_pin, 1'b0);
    rchk("ctrl", 8'h00, 32'h00026225);
    wreg(8'h08, 32'h0);
    rchk("delay", 8'h08, 32'h64);
    rchk("unmapped", 8'hfc, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_edges();
    field_u.pulses(3);
    rchk("single edge", 8'h0c, 32'd3);
    wreg(8'h00, cw(2, 1, 1, 1, 3));
    field_u.pulses(2);
    rchk("two edge", 8'h0c, 32'd7);
    wreg(8'h00, cw(2, 1, 1, 1, 3) | 32'h40000);
    wreg(8'h00, cw(1, 1, 1, 1, 3) | 32'h40000);
    field_u.pulses(1);
    rchk("edge locked", 8'h0c, 32'd9);
    wreg(8'h00, cw(1, 1, 1, 1, 3));
    wreg(8'h00, cw(1, 1, 1, 1, 3));
    $display("test edges done");
  endtask
  task automatic t_scale();
    int dv[4] = '{1, 10, 100, 1000};
    wreg(8'h04, 32'd2345);
    wreg(8'h00, cw(1, 1, 1, 2, 3));
    field_u.hold(1'b1, 1'b1);
    field_u.hold(1'b0, 1'b1);
    rchk("to preset", 8'h0c, 32'd2345);
    for (int s = 1; s <= 4; s++) begin
      wreg(8'h00, cw(1, s, 1, 2, 3));
      repeat (3) @(posedge clk);
      rchk("scaled", 8'h10, 32'(2345 / dv[s - 1]));
    end
    wreg(8'h00, cw(1, 1, 1, 1, 3));
    field_u.hold(1'b1, 1'b0);
    field_u.hold(1'b0, 1'b0);
    rchk("to zero", 8'h0c, 32'd0);
    $display("test scale done");
  endtask
  task automatic t_dp();
    for (int p = 1; p <= 6; p++) begin
      for (int n = 0; n < 2; n++) begin
        wreg(8'h00, cw(1, 1, p, 1, 3) | 32'(n << 8));
        repeat (3) @(posedge clk);
        chk("dp mask", dp_mask, (p == 1) ? 6'h00 : 6'(6'h01 << (p - 1)));
        chk("blanking", leading_zero_blank, 1'(n == 0));
      end
    end
    $display("test dp done");
  endtask
  task automatic t_mom();
    wreg(8'h00, cw(1, 1, 1, 1, 3));
    field_u.hold(1'b1, 1'b0);
    field_u.pulses(2);
    rchk("held", 8'h0c, 32'd0);
    field_u.hold(1'b0, 1'b0);
    field_u.pulses(2);
    wreg(8'h00, cw(1, 1, 1, 1, 3) | 32'h1000);
    field_u.hold(1'b1, 1'b0);
    field_u.pulses(3);
    rchk("momentary", 8'h0c, 32'd3);
    chk("frozen", display, 32'd2);
    field_u.hold(1'b0, 1'b0);
    chk("released", display, 32'd3);
    $display("test momentary done");
  endtask
  task automatic t_out();
    wreg(8'h04, 32'd3);
    wreg(8'h00, cw(1, 1, 1, 1, 3));
    field_u.hold(1'b1, 1'b0);
    field_u.hold(1'b0, 1'b0);
    field_u.pulses(3);
    chk("on at preset", out1_pin, 1'b1);
    field_u.pulses(1);
    chk("latched", out1_pin, 1'b1);
    field_u.hold(1'b1, 1'b0);
    chk("cleared", out1_pin, 1'b0);
    field_u.hold(1'b0, 1'b0);
    wreg(8'h00, cw(1, 1, 1, 1, 4));
    field_u.pulses(3);
    field_u.hold(1'b1, 1'b0);
    chk("through reset", out1_pin, 1'b1);
    field_u.hold(1'b0, 1'b0);
    chk("reset end", out1_pin, 1'b0);
    wreg(8'h08, 32'd5);
    wreg(8'h00, cw(1, 1, 1, 1, 5));
    field_u.pulses(3);
    chk("delay on", out1_pin, 1'b1);
    for (k = 0; k < 80 && out1_pin; k++) @(posedge clk);
    chk("delay length", 1'(k >= 25 && k <= 60), 1'b1);
    if (k == 80) print_verdict();
    field_u.hold(1'b1, 1'b0);
    field_u.hold(1'b0, 1'b0);
    field_u.pulses(3);
    field_u.hold(1'b1, 1'b0);
    chk("delay cut", out1_pin, 1'b0);
    field_u.hold(1'b0, 1'b0);
    wreg(8'h00, cw(1, 1, 1, 1, 3) | 32'h10000);
    repeat (3) @(posedge clk);
    chk("reverse rest", out1_pin, 1'b1);
    field_u.pulses(3);
    chk("reverse on", out1_pin, 1'b0);
    wreg(8'h00, cw(1, 1, 1, 1, 6));
    repeat (3) @(posedge clk);
    chk("at boundary", out1_pin, 1'b1);
    field_u.hold(1'b1, 1'b0);
    chk("below boundary", out1_pin, 1'b0);
    field_u.hold(1'b0, 1'b0);
    $display("test outputs done");
  endtask
  task automatic t_auto();
    wreg(8'h00, cw(1, 1, 1, 1, 1));
    field_u.hold(1'b1, 1'b0);
    field_u.hold(1'b0, 1'b0);
    field_u.pulses(3);
    chk("t1 on", out1_pin, 1'b1);
    out2_active <= 1'b1;
    repeat (3) @(posedge clk);
    chk("t1 out2 start", out1_pin, 1'b0);
    out2_active <= 1'b0;
    wreg(8'h00, cw(1, 1, 1, 1, 2));
    field_u.hold(1'b1, 1'b0);
    field_u.hold(1'b0, 1'b0);
    field_u.pulses(3);
    out2_active <= 1'b1;
    repeat (3) @(posedge clk);
    chk("t2 out2 on", out1_pin, 1'b1);
    out2_active <= 1'b0;
    repeat (3) @(posedge clk);
    chk("t2 out2 end", out1_pin, 1'b0);
    wreg(8'h00, cw(1, 1, 1, 5, 3));
    field_u.hold(1'b1, 1'b0);
    field_u.hold(1'b0, 1'b0);
    field_u.pulses(3);
    rchk("mode5 zero", 8'h0c, 32'd0);
    chk("mode5 out", out1_pin, 1'b1);
    wreg(8'h00, cw(1, 1, 1, 3, 5));
    field_u.hold(1'b1, 1'b0);
    field_u.hold(1'b0, 1'b0);
    field_u.pulses(3);
    rchk("mode3 count", 8'h0c, 32'd3);
    repeat (70) @(posedge clk);
    rchk("mode3 expiry", 8'h0c, 32'd0);
    boundary_saved <= 1'b1;
    reset <= 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    chk("out1 after rerun", out1_pin, 1'b0);
    boundary_saved <= 1'b0;
    $display("test auto done");
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    t_regs();
    field_u.hold(1'b1, 1'b0);
    field_u.hold(1'b0, 1'b0);
    t_edges();
    t_scale();
    t_dp();
    t_mom();
    t_out();
    t_auto();
    print_verdict();
  end
endmodule

`default_nettype wire
